// >>> logic/sflp_regs.vh
// Register map, field positions, reset values and timing counts of the sector protection block.
// Assumes a 32-bit APB bus with byte addresses and one aligned word per register.
`ifndef SFLP_REGS_VH
`define SFLP_REGS_VH

`define SFLP_A_STATUS 8'h00
`define SFLP_A_FLAG 8'h04
`define SFLP_A_LOCK_SEL 8'h08
`define SFLP_A_LOCK_DATA 8'h0c
`define SFLP_A_OP_ADDR 8'h10
`define SFLP_A_OP_CTRL 8'h14
`define SFLP_A_OP_STAT 8'h18

`define SFLP_ST_BP_LSB 0
`define SFLP_ST_BP_MSB 3
`define SFLP_ST_TB 4
`define SFLP_ST_SWD 7
`define SFLP_ST_RESET 8'h00

`define SFLP_FLAG_PROT 1

`define SFLP_LK_WL 0
`define SFLP_LK_LD 1
`define SFLP_LK_RESET 2'h0

`define SFLP_OC_WRITE_ENABLE_CMD 0
`define SFLP_OC_PROG 1
`define SFLP_OC_SERASE 2
`define SFLP_OC_SSERASE 3
`define SFLP_OC_SUSP 4
`define SFLP_OC_RESUME 5

`define SFLP_OS_BUSY 0
`define SFLP_OS_PSUSP 1
`define SFLP_OS_ESUSP 2
`define SFLP_OS_WEL 3
`define SFLP_OS_FAIL 4

`define SFLP_KIND_NONE 2'h0
`define SFLP_KIND_PROG 2'h1
`define SFLP_KIND_SERASE 2'h2
`define SFLP_KIND_SSERASE 2'h3

`define SFLP_SECTORS 256
`define SFLP_SEC_MSB 23
`define SFLP_SEC_LSB 16
`define SFLP_MODIFY_CYCLES 16'h0010
`define SFLP_CNT_ONE 16'h0001

`endif

// >>> logic/sflp_range_check.v
// Block-range decoder: tells whether one sector lies in the region set by the range code.
// Assumes the four-bit range code and select come straight from the status register.
`timescale 1ns/1ps
module sflp_range_check (
  input wire [3:0] range_code,
  input wire top_bottom_select,
  input wire [7:0] sector,
  output reg in_range
);
  reg [7:0] low_mask;
  always @* begin
    low_mask = 8'h00;
    in_range = 1'b0;
    if (range_code == 4'h0) begin
      in_range = 1'b0;
    end else if (range_code > 4'h8) begin
      in_range = 1'b1;
    end else begin
      // Ones below the boundary bit: 2^(n-1) sectors share the same upper bits.
      low_mask = (8'h01 << (range_code - 4'h1)) - 8'h01;
      if (top_bottom_select) begin
        in_range = ((sector & ~low_mask) == 8'h00);
      end else begin
        in_range = ((sector | low_mask) == 8'hff);
      end
    end
  end
endmodule // sflp_range_check

// >>> logic/sflp_sector_protect.v
// Sector protection controller: lock registers, range protection, status and operation gate.
// Assumes an APB master on pclk and an array controller that acts on modify_start.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "sflp_regs.vh"
module sflp_sector_protect (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire write_protect_n,
  output reg modify_start,
  output reg [1:0] modify_kind,
  output reg [23:0] modify_addr,
  output reg modify_busy
);
  reg [1:0] lock_q [0:`SFLP_SECTORS-1];
  reg [7:0] status_q;
  reg prot_flag_q;
  reg [7:0] lock_sel_q;
  reg [23:0] op_addr_q;
  reg write_enable_latch_q;
  reg prog_susp_q;
  reg erase_susp_q;
  reg fail_q;
  reg [15:0] cnt_q;
  reg [31:0] rd_data;
  reg addr_ok;
  integer i;

  wire acc_cycle = psel & penable & pready;
  wire acc_wr = acc_cycle & pwrite;
  wire hw_protect = status_q[`SFLP_ST_SWD] & ~write_protect_n;
  wire [7:0] op_sector = op_addr_q[`SFLP_SEC_MSB:`SFLP_SEC_LSB];
  wire [1:0] sel_lock = lock_q[lock_sel_q];
  wire [1:0] op_lock = lock_q[op_sector];
  wire range_hit;
  wire suspended = prog_susp_q | erase_susp_q;
  wire idle = ~modify_busy & ~suspended;

  sflp_range_check u_range (
    .range_code(status_q[`SFLP_ST_BP_MSB:`SFLP_ST_BP_LSB]),
    .top_bottom_select(status_q[`SFLP_ST_TB]),
    .sector(op_sector),
    .in_range(range_hit)
  );

  // Either mechanism alone is enough to protect the target sector.
  wire sector_protected = op_lock[`SFLP_LK_WL] | range_hit;

  wire wr_status = acc_wr & (paddr == `SFLP_A_STATUS) & write_enable_latch_q;
  wire status_refused = wr_status & hw_protect;
  wire wr_lock = acc_wr & (paddr == `SFLP_A_LOCK_DATA) & write_enable_latch_q;
  // Lock-down freezes the pair; a suspended program blocks locking altogether.
  wire lock_apply = wr_lock & ~sel_lock[`SFLP_LK_LD] & ~prog_susp_q;
  wire wr_ctrl = acc_wr & (paddr == `SFLP_A_OP_CTRL);
  wire op_req = wr_ctrl & (pwdata[`SFLP_OC_PROG] | pwdata[`SFLP_OC_SERASE] |
                           pwdata[`SFLP_OC_SSERASE]);
  wire op_take = op_req & write_enable_latch_q & idle;
  wire op_reject = op_take & sector_protected;
  wire op_start = op_take & ~sector_protected;
  wire prot_set = op_reject | status_refused;
  wire prot_clr = acc_wr & (paddr == `SFLP_A_FLAG) & pwdata[`SFLP_FLAG_PROT];

  always @* begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `SFLP_A_STATUS: rd_data[7:0] = status_q;
      `SFLP_A_FLAG: rd_data[`SFLP_FLAG_PROT] = prot_flag_q;
      `SFLP_A_LOCK_SEL: rd_data[7:0] = lock_sel_q;
      `SFLP_A_LOCK_DATA: rd_data[1:0] = sel_lock;
      `SFLP_A_OP_ADDR: rd_data[23:0] = op_addr_q;
      `SFLP_A_OP_CTRL: rd_data = 32'h00000000;
      `SFLP_A_OP_STAT: begin
        rd_data[`SFLP_OS_BUSY] = modify_busy;
        rd_data[`SFLP_OS_PSUSP] = prog_susp_q;
        rd_data[`SFLP_OS_ESUSP] = erase_susp_q;
        rd_data[`SFLP_OS_WEL] = write_enable_latch_q;
        rd_data[`SFLP_OS_FAIL] = fail_q;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // Bus side: one wait state, so every answer comes from a flip-flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
        pslverr <= ~addr_ok;
      end
    end
  end

  // Lock bits live only here and reset only with presetn.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `SFLP_SECTORS; i = i + 1) begin
        lock_q[i] <= `SFLP_LK_RESET;
      end
    end else if (lock_apply) begin
      // During an erase suspend the bits change at once; the running erase was
      // checked when it started and is not checked again on resume.
      lock_q[lock_sel_q] <= pwdata[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `SFLP_ST_RESET;
      prot_flag_q <= 1'b0;
      lock_sel_q <= 8'h00;
      op_addr_q <= 24'h000000;
      write_enable_latch_q <= 1'b0;
      prog_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
      fail_q <= 1'b0;
      cnt_q <= 16'h0000;
      modify_start <= 1'b0;
      modify_kind <= `SFLP_KIND_NONE;
      modify_addr <= 24'h000000;
      modify_busy <= 1'b0;
    end else begin
      modify_start <= 1'b0;
      // A violation in the same cycle as a clear keeps the flag set.
      prot_flag_q <= prot_set | (prot_flag_q & ~prot_clr);
      if (wr_status & ~hw_protect) begin
        status_q <= {pwdata[`SFLP_ST_SWD], 2'b00, pwdata[`SFLP_ST_TB:0]};
      end
      if (acc_wr & (paddr == `SFLP_A_LOCK_SEL)) begin
        lock_sel_q <= pwdata[7:0];
      end
      if (acc_wr & (paddr == `SFLP_A_OP_ADDR) & idle) begin
        op_addr_q <= pwdata[23:0];
      end
      // The latch is consumed by any status or lock write and by any operation taken while idle, even one that is refused.
      if (wr_status | wr_lock | op_take) begin
        write_enable_latch_q <= 1'b0;
      end else if (wr_ctrl & pwdata[`SFLP_OC_WRITE_ENABLE_CMD]) begin
        write_enable_latch_q <= 1'b1;
      end
      if (op_take) begin
        fail_q <= op_reject;
      end
      if (op_start) begin
        // Only an accepted operation reaches the array.
        modify_start <= 1'b1;
        modify_busy <= 1'b1;
        modify_addr <= op_addr_q;
        cnt_q <= `SFLP_MODIFY_CYCLES;
        if (pwdata[`SFLP_OC_PROG]) begin
          modify_kind <= `SFLP_KIND_PROG;
        end else if (pwdata[`SFLP_OC_SERASE]) begin
          modify_kind <= `SFLP_KIND_SERASE;
        end else begin
          modify_kind <= `SFLP_KIND_SSERASE;
        end
      end else if (modify_busy & ~suspended) begin
        if (wr_ctrl & pwdata[`SFLP_OC_SUSP]) begin
          if (modify_kind == `SFLP_KIND_PROG) begin
            prog_susp_q <= 1'b1;
          end else begin
            erase_susp_q <= 1'b1;
          end
        end else if (cnt_q == `SFLP_CNT_ONE) begin
          modify_busy <= 1'b0;
          modify_kind <= `SFLP_KIND_NONE;
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= cnt_q - `SFLP_CNT_ONE;
        end
      end else if (suspended & wr_ctrl & pwdata[`SFLP_OC_RESUME]) begin
        prog_susp_q <= 1'b0;
        erase_susp_q <= 1'b0;
      end
    end
  end
endmodule // sflp_sector_protect

// >>> bench/sflp_checker.sv
// Port checks of the sector protection block.
// Assumes one pclk domain and a one-wait-state APB slave.
`timescale 1ns/1ps
module sflp_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic pready,
  input logic pslverr,
  input logic modify_start,
  input logic [1:0] modify_kind,
  input logic [23:0] modify_addr,
  input logic modify_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && !pready;
  wire opw = pready && pwrite && paddr == 8'h14;
  chk_rdy_wait: assert property (acc |=> pready)
    else $error("ready late");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_bad_addr: assert property (acc && paddr > 8'h18 |=> pslverr && pready)
    else $error("unmapped not refused");
  chk_start_pulse: assert property (modify_start |=> !modify_start)
    else $error("start too long");
  chk_start_kind: assert property (modify_start |-> modify_kind != 2'h0)
    else $error("start without kind");
  chk_busy_run: assert property (modify_start |=> modify_busy [*8])
    else $error("busy dropped early");
  chk_target_hold: assert property (modify_start |=>
    ($stable(modify_addr) && $stable(modify_kind)) [*8])
    else $error("target changed");
  chk_start_cause: assert property (modify_start |-> $past(opw) || $past(opw, 2))
    else $error("start without request");
  cover property (modify_start);
  cover property (acc && paddr > 8'h18);
  cover property (modify_busy ##1 !modify_busy);
endmodule // sflp_checker

// >>> bench/sflp_host.sv
// APB host model standing in for the flash command controller.
// Assumes one caller at a time.
`timescale 1ns/1ps
module sflp_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic tmo = 1'b0;
  // One initial only, so the idle bus never starts selected by a race between two writers.
  initial {psel, penable, pwrite, paddr, pwdata} = {2'h0, 1'b1, 8'hff, 32'hffffffff};
  // Any register, lock registers included, is read or written here.
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
                      output logic er);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20 && !pready; i++)
      @(posedge pclk);
    tmo = i == 20;
    q = prdata;
    er = pslverr;
    // A released bus shows inverted values so a stale address never passes.
    {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
  endtask
endmodule // sflp_host

// >>> bench/sflp_sector_protect_bench.sv
// Bench with a lock and range model judging every result.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`include "sflp_regs.vh"
module sflp_sector_protect_bench;
  logic pclk = 0, presetn = 0, wp_n = 1, ps = 0, e, psel, penable, pwrite, pready, pslverr;
  logic ms, mb;
  logic [1:0] mk, kd;
  logic [7:0] paddr;
  logic [23:0] ma, ka;
  int ea;
  logic [31:0] pwdata, prdata, r;
  int n_mismatch = 0, n_checks = 0, n_st = 0, n0, ek, w, st, lk[256], seed = 32'h7480;
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (ms) n_st <= n_st + 1;
    if (ms) kd <= mk;
    if (ms) ka <= ma;
  end
  sflp_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sflp_sector_protect i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_protect_n(wp_n), .modify_start(ms),
    .modify_kind(mk), .modify_addr(ma), .modify_busy(mb));
  task automatic chk(logic [31:0] g, logic [31:0] x);
    n_checks++;
    if (g !== x) n_mismatch++;
    if (g !== x) $display("[FAIL] %0t got %h exp %h", $time, g, x);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    i_host.xfer(w, a, d, r, e);
    chk(i_host.tmo, 0);
    if (i_host.tmo) test_done;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    bus(0, a, 0);
    chk(r, x);
  endtask
  task automatic m(logic [7:0] a, logic [31:0] d);
    bus(1, `SFLP_A_OP_CTRL, 1);
    bus(1, a, d);
  endtask
  task automatic sst(int v);
    m(`SFLP_A_STATUS, v);
    if (!st[7] || wp_n) st = v;
    rd(`SFLP_A_STATUS, st);
  endtask
  task automatic slk(int s, int v);
    bus(1, `SFLP_A_LOCK_SEL, s);
    m(`SFLP_A_LOCK_DATA, v);
    if (!lk[s][1] && !ps) lk[s] = v;
    rd(`SFLP_A_LOCK_DATA, lk[s]);
  endtask
  function automatic int prot(int s);
    int c = st & 15;
    int b = (1 << c) >> 1;
    return lk[s][0] || c > 8 || (st[4] ? s < b : s >= 256 - b);
  endfunction
  task automatic go(int s, int k);
    n0 = n_st;
    ek = k;
    ea = (s & 255) << 16;
    bus(1, `SFLP_A_OP_ADDR, s << 16);
    m(`SFLP_A_OP_CTRL, 1 << k);
  endtask
  task automatic fin(int p);
    int i;
    for (i = 0; i < 40 && (i < 3 || mb); i++)
      @(negedge pclk);
    chk(i == 40, 0);
    if (i == 40) test_done;
    chk(n_st - n0, !p);
    if (!p) chk(kd, ek);
    if (!p) chk(ka, ea);
    rd(`SFLP_A_OP_STAT, p << 4);
    rd(`SFLP_A_FLAG, p << 1);
    bus(1, `SFLP_A_FLAG, 2);
  endtask
  task automatic op(int s, int k);
    int p = prot(s);
    go(s, k);
    fin(p);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(`SFLP_A_OP_STAT, 0);
    bus(0, 8'h1c, 0);
    chk(e, 1);
    chk(r, 0);
    for (int c = 0; c < 32; c++) begin
      sst(c);
      w = (1 << (c & 15)) >> 1;
      for (int j = 0; j < 5; j++)
        op((j == 4 ? $random(seed) : j < 2 ? w - 1 + j : 258 - w - j) & 255, 1 + j % 3);
    end
    $display("range test done");
    sst(0);
    slk(5, 1);
    op(5, 1);
    slk(5, 0);
    op(5, 2);
    slk(5, 3);
    slk(5, 0);
    sst(8'h11);
    op(0, 1);
    op(9, 3);
    sst(8'h81);
    @(posedge pclk) wp_n <= 0;
    sst(8'h02);
    rd(`SFLP_A_FLAG, 2);
    bus(1, `SFLP_A_FLAG, 2);
    @(posedge pclk) wp_n <= 1;
    sst(0);
    go(6, 2);
    bus(1, `SFLP_A_OP_CTRL, 16);
    rd(`SFLP_A_OP_STAT, 5);
    slk(6, 1);
    bus(1, `SFLP_A_OP_CTRL, 32);
    fin(0);
    go(7, 1);
    bus(1, `SFLP_A_OP_CTRL, 16);
    ps = 1;
    rd(`SFLP_A_OP_STAT, 3);
    slk(7, 1);
    ps = 0;
    bus(1, `SFLP_A_OP_CTRL, 32);
    fin(0);
    $display("lock test done");
    @(posedge pclk) presetn <= 0;
    lk = '{default: 0};
    @(posedge pclk) presetn <= 1;
    slk(5, 2);
    $display("reset test done");
    test_done;
  end
endmodule // sflp_sector_protect_bench
bind sflp_sector_protect sflp_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .modify_start(modify_start), .modify_kind(modify_kind), .modify_addr(modify_addr),
  .modify_busy(modify_busy));
